//--- jk_edge_flip_flop_gated.v
`include "jk_edge_map.vh"
`default_nettype none

module jk_edge_flip_flop_gated
(
	// System
	input wire clk_i,
	input wire rst_n_i,
	// Gated variant pins
	input wire jk_clk_i,
	input wire set_gate_in_a_i,
	input wire set_gate_in_b_i,
	input wire set_gate_in_c_i,
	input wire reset_gate_in_a_i,
	input wire reset_gate_in_b_i,
	input wire reset_gate_in_c_i,
	input wire clear_n_i,
	input wire preset_n_i,
	// Dual variant pins, one bit per flip-flop
	input wire [1:0] dual_clk_i,
	input wire [1:0] dual_j_i,
	input wire [1:0] dual_k_i,
	input wire [1:0] dual_clear_n_i,
	// Outputs
	output reg gated_q_o,
	output reg gated_q_n_o,
	output wire [1:0] dual_q_o,
	output wire [1:0] dual_q_n_o
);

	// ****************************************
	// Next-state function shared by all flip-flops
	// ****************************************
	// Pure table lookup; the default branch keeps the state on an unknown code
	function next_state;
		input [1:0] jk;
		input cur;
		begin
			case (jk)
				`JK_HOLD: next_state = cur;
				`JK_LOW: next_state = 1'h0;
				`JK_HIGH: next_state = 1'h1;
				`JK_TOGGLE: next_state = ~cur;
				default: next_state = cur;
			endcase
		end
	endfunction

	// ****************************************
	// Gated flip-flop
	// ****************************************
	// Pins are asynchronous: three stages, a change counts when stages 2 and 3 agree
	// Limitation: a pin level must stand about three clk_i cycles before it is seen
	reg [2:0] g_clk_s_r, g_j_s_r, g_k_s_r, g_clr_s_r, g_pre_s_r;
	reg g_clk_v_r, g_j_v_r, g_k_v_r, g_clr_v_r, g_pre_v_r;
	reg g_j_arm_r, g_k_arm_r;
	reg g_state_r;
	// Gates are ANDed before the synchroniser, so one chain serves each of J and K
	wire g_j_and = set_gate_in_a_i & set_gate_in_b_i & set_gate_in_c_i;
	wire g_k_and = reset_gate_in_a_i & reset_gate_in_b_i & reset_gate_in_c_i;
	// Fall seen once: validated level still high while stages 2 and 3 agree low
	wire g_fall = g_clk_v_r & (g_clk_s_r[2] == g_clk_s_r[1]) & ~g_clk_s_r[2];
	// Next state, settled by the priority chain below
	reg g_state_nxt;

	// Synchronisers and validated levels
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			// Clock, J and K idle low; clear and preset idle high, so no false edge
			g_clk_s_r <= `JK_SYNC_IDLE_LO;
			g_j_s_r <= `JK_SYNC_IDLE_LO;
			g_k_s_r <= `JK_SYNC_IDLE_LO;
			g_clr_s_r <= `JK_SYNC_IDLE_HI;
			g_pre_s_r <= `JK_SYNC_IDLE_HI;
			g_clk_v_r <= `JK_LVL_IDLE_LO;
			g_j_v_r <= `JK_LVL_IDLE_LO;
			g_k_v_r <= `JK_LVL_IDLE_LO;
			g_clr_v_r <= `JK_LVL_IDLE_HI;
			g_pre_v_r <= `JK_LVL_IDLE_HI;
		end
		else
		begin
			g_clk_s_r <= {g_clk_s_r[1:0], jk_clk_i};
			g_j_s_r <= {g_j_s_r[1:0], g_j_and};
			g_k_s_r <= {g_k_s_r[1:0], g_k_and};
			g_clr_s_r <= {g_clr_s_r[1:0], clear_n_i};
			g_pre_s_r <= {g_pre_s_r[1:0], preset_n_i};
			if (g_clk_s_r[2] == g_clk_s_r[1]) g_clk_v_r <= g_clk_s_r[2];
			if (g_j_s_r[2] == g_j_s_r[1]) g_j_v_r <= g_j_s_r[2];
			if (g_k_s_r[2] == g_k_s_r[1]) g_k_v_r <= g_k_s_r[2];
			if (g_clr_s_r[2] == g_clr_s_r[1]) g_clr_v_r <= g_clr_s_r[2];
			if (g_pre_s_r[2] == g_pre_s_r[1]) g_pre_v_r <= g_pre_s_r[2];
		end
	end

	// Inputs are latched only while clock is high, frozen while low
	// Arming lags one cycle, so J and K need a few clk_i cycles of setup
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			g_j_arm_r <= `JK_LVL_IDLE_LO;
			g_k_arm_r <= `JK_LVL_IDLE_LO;
		end
		else if (g_clk_v_r)
		begin
			g_j_arm_r <= g_j_v_r;
			g_k_arm_r <= g_k_v_r;
		end
	end

	// Clear and preset win over the edge; both active gives clear
	always @*
	begin
		g_state_nxt = g_state_r;
		if (!g_clr_v_r)
			g_state_nxt = 1'h0;
		else if (!g_pre_v_r)
			g_state_nxt = 1'h1;
		else if (g_fall)
			g_state_nxt = next_state({g_j_arm_r, g_k_arm_r}, g_state_r);
	end

	// Outputs registered from the next state so both stay complementary
	// Costs a flop per output but keeps them free of glitches
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			g_state_r <= `JK_STATE_RST;
			gated_q_o <= `JK_STATE_RST;
			gated_q_n_o <= ~`JK_STATE_RST;
		end
		else
		begin
			g_state_r <= g_state_nxt;
			gated_q_o <= g_state_nxt;
			gated_q_n_o <= ~g_state_nxt;
		end
	end

	// ****************************************
	// Dual flip-flops, fully independent
	// ****************************************
	// Each flop owns its output pair, so no bus bit has two drivers
	genvar gi;
	generate
		for (gi = 0; gi < `JK_DUAL_COUNT; gi = gi + 1)
		begin : dual_ff
			reg [2:0] clk_s_r, j_s_r, k_s_r, clr_s_r;
			reg clk_v_r, j_v_r, k_v_r, clr_v_r, j_arm_r, k_arm_r, st_r;
			reg q_r, q_n_r;
			reg st_nxt;
			// Same single-shot fall detect as the gated flop
			wire fall = clk_v_r & (clk_s_r[2] == clk_s_r[1]) & ~clk_s_r[2];

			// Port bits come straight from this flop's output registers
			assign dual_q_o[gi] = q_r;
			assign dual_q_n_o[gi] = q_n_r;

			// Clear beats the edge; these flops have no preset
			always @*
			begin
				st_nxt = st_r;
				if (!clr_v_r)
					st_nxt = 1'h0;
				else if (fall)
					st_nxt = next_state({j_arm_r, k_arm_r}, st_r);
			end

			// Synchroniser, arming and state of one flop
			always @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					clk_s_r <= `JK_SYNC_IDLE_LO;
					j_s_r <= `JK_SYNC_IDLE_LO;
					k_s_r <= `JK_SYNC_IDLE_LO;
					clr_s_r <= `JK_SYNC_IDLE_HI;
					clk_v_r <= `JK_LVL_IDLE_LO;
					j_v_r <= `JK_LVL_IDLE_LO;
					k_v_r <= `JK_LVL_IDLE_LO;
					clr_v_r <= `JK_LVL_IDLE_HI;
					j_arm_r <= `JK_LVL_IDLE_LO;
					k_arm_r <= `JK_LVL_IDLE_LO;
					st_r <= `JK_STATE_RST;
					q_r <= `JK_STATE_RST;
					q_n_r <= ~`JK_STATE_RST;
				end
				else
				begin
					clk_s_r <= {clk_s_r[1:0], dual_clk_i[gi]};
					j_s_r <= {j_s_r[1:0], dual_j_i[gi]};
					k_s_r <= {k_s_r[1:0], dual_k_i[gi]};
					clr_s_r <= {clr_s_r[1:0], dual_clear_n_i[gi]};
					if (clk_s_r[2] == clk_s_r[1]) clk_v_r <= clk_s_r[2];
					if (j_s_r[2] == j_s_r[1]) j_v_r <= j_s_r[2];
					if (k_s_r[2] == k_s_r[1]) k_v_r <= k_s_r[2];
					if (clr_s_r[2] == clr_s_r[1]) clr_v_r <= clr_s_r[2];
					if (clk_v_r)
					begin
						j_arm_r <= j_v_r;
						k_arm_r <= k_v_r;
					end
					st_r <= st_nxt;
					q_r <= st_nxt;
					q_n_r <= ~st_nxt;
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

//--- jk_edge_map.vh
`ifndef JK_EDGE_MAP_VH
`define JK_EDGE_MAP_VH
// Reset value of every stored state bit
`define JK_STATE_RST 1'h0
// Synchroniser reset patterns for pins that idle low and pins that idle high
`define JK_SYNC_IDLE_LO 3'h0
`define JK_SYNC_IDLE_HI 3'h7
// Validated level reset values for the same two cases
`define JK_LVL_IDLE_LO 1'h0
`define JK_LVL_IDLE_HI 1'h1
// Synchroniser depth for pin inputs
`define JK_SYNC_DEPTH 3
// Number of flip-flops in the dual variant
`define JK_DUAL_COUNT 2
// J/K codes of the next-state table
`define JK_HOLD 2'h0
`define JK_LOW 2'h1
`define JK_HIGH 2'h2
`define JK_TOGGLE 2'h3
`endif

//--- jk_drv.sv
`default_nettype none
// ****
// Pin driver
// ****
module jk_drv (
	// Clock in, pins out
	input wire logic clk_i,
	output logic ck_o,
	output logic [2:0] j_o,
	output logic [2:0] k_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {ck_o, j_o, k_o} = 7'h0;
	// One clock pulse; J/K scrambled while low to show they are ignored
	task pulse(input logic [5:0] c);
		ck_o = 1'h1;
		repeat (4) @(negedge clk_i);
		{j_o, k_o} = c;
		repeat (8) @(negedge clk_i);
		ck_o = 1'h0;
		repeat (2) @(negedge clk_i);
		{j_o, k_o} = ~c;
		repeat (6) @(negedge clk_i);
	endtask
endmodule
`default_nettype wire

//--- jk_edge_flip_flop_gated_chk.sv
`default_nettype none
// ****
// Checker
// ****
module jk_chk (
	// Clock, reset and pins
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic jk_clk_i,
	input wire logic clear_n_i,
	input wire logic preset_n_i,
	input wire logic [1:0] dual_clk_i,
	input wire logic [1:0] dual_clear_n_i,
	// Outputs
	input wire logic gated_q_o,
	input wire logic gated_q_n_o,
	input wire logic [1:0] dual_q_o,
	input wire logic [1:0] dual_q_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Pins pass a synchroniser, so six cycles of margin, eight for the stability checks
	property p_cpl; gated_q_n_o == !gated_q_o; endproperty
	a_cpl: assert property (p_cpl) else $error("cpl");
	property p_dcpl; dual_q_n_o == ~dual_q_o; endproperty
	a_dcpl: assert property (p_dcpl) else $error("dcpl");
	property p_clr; !clear_n_i [*6] |-> !gated_q_o; endproperty
	a_clr: assert property (p_clr) else $error("clr");
	property p_clf; $fell(clear_n_i) |-> ##[1:6] !gated_q_o; endproperty
	a_clf: assert property (p_clf) else $error("clf");
	property p_pre; (clear_n_i && !preset_n_i) [*6] |-> gated_q_o; endproperty
	a_pre: assert property (p_pre) else $error("pre");
	property p_stb; (clear_n_i && preset_n_i && $stable(jk_clk_i)) [*8] |=> $stable(gated_q_o);
	endproperty
	a_stb: assert property (p_stb) else $error("stb");
	property p_dstb; (&dual_clear_n_i && $stable(dual_clk_i)) [*8] |=> $stable(dual_q_o);
	endproperty
	a_dstb: assert property (p_dstb) else $error("dstb");
	property p_dc0; !dual_clear_n_i[0] [*6] |-> !dual_q_o[0]; endproperty
	a_dc0: assert property (p_dc0) else $error("dc0");
	cover property (!clear_n_i && !preset_n_i);
	cover property ($fell(jk_clk_i) ##6 gated_q_o);
	cover property ($changed(dual_q_o));
endmodule
bind jk_edge_flip_flop_gated jk_chk chk_u (.clk_i, .rst_n_i, .jk_clk_i, .clear_n_i,
	.preset_n_i, .dual_clk_i, .dual_clear_n_i, .gated_q_o, .gated_q_n_o, .dual_q_o, .dual_q_n_o);
`default_nettype wire

//--- jk_edge_flip_flop_gated_tb_top.sv
`default_nettype none
// ****
// Testbench
// ****
module jk_edge_flip_flop_gated_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'h0, rst_n_i = 1'h0, clear_n_i = 1'h1, preset_n_i = 1'h1, e = 1'h0;
	logic [1:0] dual_clk_i = 2'h0, dual_clear_n_i = 2'h3, dual_j_i = 2'h3, dual_k_i = 2'h0;
	wire logic jk_clk_i, gated_q_o, gated_q_n_o;
	wire logic [2:0] j, k;
	wire logic [1:0] dual_q_o, dual_q_n_o;
	wire logic [3:0] gq = {2'h0, gated_q_o, gated_q_n_o};
	wire logic [3:0] dq = {dual_q_o, dual_q_n_o};
	int n_errors = 0, cmp_count = 0, cyc = 0;
	// Clock and hang ceiling
	initial forever #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) if (++cyc > 600) begin n_errors++; end_of_test; end
	jk_drv drv_u (.clk_i, .ck_o(jk_clk_i), .j_o(j), .k_o(k));
	jk_edge_flip_flop_gated dut_u (.clk_i, .rst_n_i, .jk_clk_i, .set_gate_in_a_i(j[2]),
		.set_gate_in_b_i(j[1]), .set_gate_in_c_i(j[0]), .reset_gate_in_a_i(k[2]),
		.reset_gate_in_b_i(k[1]), .reset_gate_in_c_i(k[0]), .clear_n_i, .preset_n_i,
		.dual_clk_i, .dual_j_i, .dual_k_i, .dual_clear_n_i, .gated_q_o,
		.gated_q_n_o, .dual_q_o, .dual_q_n_o);
	task chk(input logic [3:0] got, exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Every J/K code, some with one gate input low
	task automatic t_jk;
		logic [5:0] c [7] = '{6'h38, 6'h3f, 6'h3f, 6'h00, 6'h1f, 6'h3e, 6'h07};
		foreach (c[i])
		begin
			drv_u.pulse(c[i]);
			e = (&c[i][5:3] && &c[i][2:0]) ? !e : (|{&c[i][5:3], &c[i][2:0]}) ? &c[i][5:3] : e;
			chk(gq, {2'h0, e, !e});
		end
	endtask
	// Preset, clear on top, then an edge under clear
	task t_async;
		preset_n_i = 1'h0;
		repeat (8) @(negedge clk_i);
		chk(gq, 4'h2);
		clear_n_i = 1'h0;
		repeat (8) @(negedge clk_i);
		chk(gq, 4'h1);
		preset_n_i = 1'h1;
		drv_u.pulse(6'h38);
		chk(gq, 4'h1);
		clear_n_i = 1'h1;
		preset_n_i = 1'h0;
		drv_u.pulse(6'h07);
		chk(gq, 4'h2);
		preset_n_i = 1'h1;
	endtask
	// Dual flops move alone
	task t_dual;
		dual_clk_i = 2'h3;
		repeat (8) @(negedge clk_i);
		dual_clk_i = 2'h2;
		repeat (8) @(negedge clk_i);
		chk(dq, 4'h6);
		dual_k_i = 2'h2;
		repeat (8) @(negedge clk_i);
		dual_clear_n_i = 2'h2;
		dual_clk_i = 2'h0;
		repeat (8) @(negedge clk_i);
		chk(dq, 4'h9);
		dual_clear_n_i = 2'h3;
		dual_clk_i = 2'h2;
		repeat (8) @(negedge clk_i);
		dual_clk_i = 2'h0;
		repeat (8) @(negedge clk_i);
		chk(dq, 4'h3);
	endtask
	initial
	begin
		repeat (20) @(negedge clk_i);
		rst_n_i = 1'h1;
		t_jk;
		t_async;
		t_dual;
		end_of_test;
	end
endmodule
`default_nettype wire
